// *** hw/chg_pkg.sv ***
// Constants, field layout and state codes of the charger register bank.
// Assumes one 40 MHz clock and a byte-wide register port behind the
// device's serial register interface.
//
// Overview of operation
// - Status bit 7 is high while chip heat reduces charge current.
// - Status bit 6 is high while the input power loop reduces charge current.
// - Status bit 5 is high while battery temperature halts charging.
// - Status bit 4 is high once termination current stopped charging.
// - Status bit 3 is high while charging, even under either reduction loop.
// - Status bit 2 is set and charging ends when any safety timer expires.
// - Status bit 1 is set and charging ends when the precharge timer expires.
// - Status bit 0 flags a missing sensor or battery temperature out of range.
// - Timer select 00/01/10/11 gives 4/5/6/8 hours; reset value 10.
// - Timer enable low stops both timers; reset value 1.
// - Sensor type bit picks the 100k (0) or 10k (1) thermistor curve.
// - Restart bit high holds the charger in reset; clearing it restarts.
// - Termination disable blocks current-based stopping; charger stays on.
// - Timer suspend pauses both safety and precharge timers.
// - Charger enable low disables the charger; reset value 1.
// - Dynamic timer bit halves timer speed while either loop is active.
// - Precharge threshold select: 0 gives 2.9 V, 1 gives 2.5 V.

package chg_pkg;

   localparam logic [7:0] STATUS_ADDR = 8'h03;
   localparam logic [7:0] CTRL_ADDR = 8'h04;
   localparam logic [7:0] VTIME_ADDR = 8'h05;

   localparam logic [7:0] STATUS_RST = 8'h00;
   localparam logic [7:0] CTRL_RST = 8'hB1;
   localparam logic [7:0] VTIME_RST = 8'h80;
   localparam logic [7:0] UNMAPPED_VAL = 8'h00;

   // Status bits
   localparam int ST_THERMAL_REGULATION_FLAG = 7;
   localparam int ST_PPATH = 6;
   localparam int ST_THERMAL_SUSPEND_FLAG = 5;
   localparam int ST_TERM = 4;
   localparam int ST_ACTIVE = 3;
   localparam int ST_CHGTO = 2;
   localparam int ST_PRETO = 1;
   localparam int ST_BTEMP = 0;

   // Control register fields
   localparam int CT_TSEL_HI = 7;
   localparam int CT_TSEL_LO = 6;
   localparam int CT_SAFETY_TIMER_ENABLE = 5;
   localparam int CT_SENSOR = 4;
   localparam int CT_RESTART = 3;
   localparam int CT_TERM_DIS = 2;
   localparam int CT_SUSPEND = 1;
   localparam int CT_ENABLE = 0;

   // Voltage and timing register fields
   localparam int VT_DYN = 7;
   localparam int VT_PRETH = 6;
   localparam int VT_VSEL_HI = 5;
   localparam int VT_VSEL_LO = 4;

   localparam int MIN_W = 9;
   localparam logic [1:0] TSEL_4H = 2'h0;
   localparam logic [1:0] TSEL_5H = 2'h1;
   localparam logic [1:0] TSEL_6H = 2'h2;
   localparam logic [MIN_W-1:0] FAST_4H_MIN = 9'h0F0;
   localparam logic [MIN_W-1:0] FAST_5H_MIN = 9'h12C;
   localparam logic [MIN_W-1:0] FAST_6H_MIN = 9'h168;
   localparam logic [MIN_W-1:0] FAST_8H_MIN = 9'h1E0;
   localparam logic [MIN_W-1:0] PRECHG_MIN = 9'h01E;

   localparam longint CLK_HZ = 40_000_000;
   localparam longint MINUTE_S = 60;
   localparam logic [31:0] MINUTE_CYCLES = 32'(CLK_HZ * MINUTE_S);

   typedef enum logic [4:0] {
      ST_IDLE = 5'b0_0001,
      ST_PRE = 5'b0_0010,
      ST_FAST = 5'b0_0100,
      ST_DONE = 5'b0_1000,
      ST_FAULT = 5'b1_0000
   } chg_state_t;

endpackage

// *** hw/chg_regs.sv ***
// Charger status and control register bank with the charge sequencer.
// Assumes a byte register port behind the serial interface, one access
// per cycle, and analog comparator levels synchronous to CLK.
`timescale 1ns/1ps

module chg_regs
   import chg_pkg::*;
#(
   parameter logic [31:0] MINUTE_CYC = MINUTE_CYCLES
)
(
   input wire logic CLK,
   input wire logic RESETN,
   input wire logic [7:0] REG_ADDR,
   input wire logic [7:0] REG_WDATA,
   input wire logic REG_WR,
   input wire logic REG_RD,
   output logic [7:0] REG_RDATA,
   input wire logic CHIP_HOT,
   input wire logic INPUT_LOOP,
   input wire logic BATT_TEMP_OUT,
   input wire logic SENSOR_MISSING,
   input wire logic TERM_CURRENT,
   input wire logic BATT_LOW,
   output logic CHARGE_ON,
   output logic CHARGER_HOLD,
   output logic SENSOR_TYPE,
   output logic PRECHG_THRESH,
   output logic [1:0] CHARGE_VSEL
);

   chg_state_t state_q, state_d;
   logic [7:0] ctrl_q, ctrl_d;
   logic [7:0] vtime_q, vtime_d;
   logic [7:0] status_q, status_d;
   logic [7:0] rdata_q, rdata_d;
   logic on_q, on_d;
   logic pre_to_q, pre_to_d;
   logic pre_exp, fast_exp;
   logic charging, active_now, hold, tmr_run, tmr_half, tmr_clear;
   logic [MIN_W-1:0] fast_limit;

   // Register writes; the status register takes no write
   always_comb
   begin
      ctrl_d = ctrl_q;
      vtime_d = vtime_q;
      if (REG_WR && REG_ADDR == CTRL_ADDR)
         ctrl_d = REG_WDATA;
      if (REG_WR && REG_ADDR == VTIME_ADDR)
         vtime_d = REG_WDATA;
   end

   // Read data is captured on the read strobe and held until the next one
   always_comb
   begin
      rdata_d = rdata_q;
      if (REG_RD)
      begin
         unique case (REG_ADDR)
            STATUS_ADDR: rdata_d = status_q;
            CTRL_ADDR: rdata_d = ctrl_q;
            VTIME_ADDR: rdata_d = vtime_q;
            default: rdata_d = UNMAPPED_VAL;
         endcase
      end
   end

   always_ff @(posedge CLK)
   begin
      if (!RESETN)
      begin
         ctrl_q <= CTRL_RST;
         vtime_q <= VTIME_RST;
         rdata_q <= UNMAPPED_VAL;
      end
      else
      begin
         ctrl_q <= ctrl_d;
         vtime_q <= vtime_d;
         rdata_q <= rdata_d;
      end
   end

   // Fast-charge limit from the timer select field
   always_comb
   begin
      unique case (ctrl_q[CT_TSEL_HI:CT_TSEL_LO])
         TSEL_4H: fast_limit = FAST_4H_MIN;
         TSEL_5H: fast_limit = FAST_5H_MIN;
         TSEL_6H: fast_limit = FAST_6H_MIN;
         default: fast_limit = FAST_8H_MIN;
      endcase
   end

   // Charge sequencer
   always_comb
   begin
      hold = ctrl_q[CT_RESTART] || !ctrl_q[CT_ENABLE];
      charging = (state_q == ST_PRE) || (state_q == ST_FAST);
      active_now = charging && !BATT_TEMP_OUT;
      state_d = state_q;
      pre_to_d = pre_to_q;
      if (hold)
      begin
         state_d = ST_IDLE;
         pre_to_d = 1'b0;
      end
      else
      begin
         unique case (state_q)
            ST_IDLE:
               state_d = BATT_LOW ? ST_PRE : ST_FAST;
            ST_PRE:
               if (pre_exp)
               begin
                  state_d = ST_FAULT;
                  pre_to_d = 1'b1;
               end
               else if (!BATT_LOW)
                  state_d = ST_FAST;
            ST_FAST:
               if (fast_exp)
                  state_d = ST_FAULT;
               else if (TERM_CURRENT && !ctrl_q[CT_TERM_DIS]
                        && !BATT_TEMP_OUT)
                  state_d = ST_DONE;
            ST_DONE, ST_FAULT:
               state_d = state_q;
            default:
               state_d = ST_IDLE;
         endcase
      end
      on_d = ((state_d == ST_PRE) || (state_d == ST_FAST))
             && !BATT_TEMP_OUT;
   end

   // Timer control
   always_comb
   begin
      tmr_run = active_now && ctrl_q[CT_SAFETY_TIMER_ENABLE]
                && !ctrl_q[CT_SUSPEND];
      tmr_half = vtime_q[VT_DYN] && (CHIP_HOT || INPUT_LOOP);
      tmr_clear = (state_d != state_q) || !ctrl_q[CT_SAFETY_TIMER_ENABLE];
   end

   // Status bits follow charger state, except bit 0, which follows the sensor and temperature inputs alone
   always_comb
   begin
      status_d = STATUS_RST;
      status_d[ST_THERMAL_REGULATION_FLAG] = active_now && CHIP_HOT;
      status_d[ST_PPATH] = active_now && INPUT_LOOP;
      status_d[ST_THERMAL_SUSPEND_FLAG] = charging && BATT_TEMP_OUT;
      status_d[ST_TERM] = (state_q == ST_DONE);
      status_d[ST_ACTIVE] = active_now;
      status_d[ST_CHGTO] = (state_q == ST_FAULT);
      status_d[ST_PRETO] = pre_to_q;
      status_d[ST_BTEMP] = SENSOR_MISSING || BATT_TEMP_OUT;
   end

   always_ff @(posedge CLK)
   begin
      if (!RESETN)
      begin
         state_q <= ST_IDLE;
         pre_to_q <= 1'b0;
         on_q <= 1'b0;
         status_q <= STATUS_RST;
      end
      else
      begin
         state_q <= state_d;
         pre_to_q <= pre_to_d;
         on_q <= on_d;
         status_q <= status_d;
      end
   end

   chg_timer #(
      .MIN_CYCLES(MINUTE_CYC)
   ) u_timer (
      .clk(CLK),
      .resetn(RESETN),
      .clear(tmr_clear),
      .run(tmr_run),
      .half(tmr_half),
      .precharge(state_q == ST_PRE),
      .fast_limit(fast_limit),
      .pre_limit(PRECHG_MIN),
      .pre_expired(pre_exp),
      .fast_expired(fast_exp)
   );

   assign REG_RDATA = rdata_q;
   assign CHARGE_ON = on_q;
   assign CHARGER_HOLD = ctrl_q[CT_RESTART];
   assign SENSOR_TYPE = ctrl_q[CT_SENSOR];
   assign PRECHG_THRESH = vtime_q[VT_PRETH];
   assign CHARGE_VSEL = vtime_q[VT_VSEL_HI:VT_VSEL_LO];

   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RESETN);

   thermal_regulation_flag_flag_a: assert property (
      charging && !BATT_TEMP_OUT && CHIP_HOT |=> status_q[ST_THERMAL_REGULATION_FLAG])
      else $error("thermal regulation flag missing");

   ppath_flag_a: assert property (
      status_q[ST_PPATH] |-> $past(INPUT_LOOP) && $past(active_now))
      else $error("power path flag without loop");

   thermal_suspend_flag_flag_a: assert property (
      charging && BATT_TEMP_OUT |=> status_q[ST_THERMAL_SUSPEND_FLAG]
      && !status_q[ST_ACTIVE] && !CHARGE_ON)
      else $error("thermal suspend not reported");

   term_done_a: assert property (
      state_q == ST_FAST && TERM_CURRENT && !BATT_TEMP_OUT && !fast_exp
      && !hold && !ctrl_q[CT_TERM_DIS]
      |=> ##1 status_q[ST_TERM] && !CHARGE_ON)
      else $error("termination not flagged");

   done_stands_a: assert property (
      state_q == ST_DONE && !hold |=> state_q == ST_DONE)
      else $error("terminated state left without restart");

   active_flag_a: assert property (
      status_q[ST_ACTIVE] == $past(active_now))
      else $error("active bit disagrees with charging");

   timeout_stop_a: assert property (
      state_q == ST_FAST && fast_exp && !hold
      |=> ##1 status_q[ST_CHGTO] && !status_q[ST_ACTIVE])
      else $error("timer expiry did not stop charging");

   pre_timeout_a: assert property (
      state_q == ST_PRE && pre_exp && !hold
      |=> ##1 status_q[ST_PRETO] && status_q[ST_CHGTO])
      else $error("precharge expiry not flagged");

   temp_fault_a: assert property (
      SENSOR_MISSING || BATT_TEMP_OUT |=> status_q[ST_BTEMP])
      else $error("temperature fault not flagged");

   timer_off_a: assert property (
      !ctrl_q[CT_SAFETY_TIMER_ENABLE] |=> !pre_exp && !fast_exp)
      else $error("timer expired while disabled");

   restart_hold_a: assert property (
      ctrl_q[CT_RESTART] |=> !CHARGE_ON && state_q == ST_IDLE)
      else $error("charger ran while held in restart");

   disable_off_a: assert property (
      !ctrl_q[CT_ENABLE] [*2] |-> !CHARGE_ON)
      else $error("charger on while disabled");

   term_disable_a: assert property (
      ctrl_q[CT_TERM_DIS] && state_q == ST_FAST && !fast_exp && !hold
      |=> state_q != ST_DONE)
      else $error("terminated while termination disabled");

   suspend_freeze_a: assert property (
      ctrl_q[CT_SUSPEND] && !tmr_clear |=> $stable(pre_exp)
      && $stable(fast_exp))
      else $error("timers moved while suspended");

   status_ro_a: assert property (
      REG_WR && REG_ADDR == STATUS_ADDR |=> $stable(ctrl_q)
      && $stable(vtime_q))
      else $error("status write changed control state");

   sensor_pin_a: assert property (
      REG_WR && REG_ADDR == CTRL_ADDR
      |=> SENSOR_TYPE == $past(REG_WDATA[CT_SENSOR]))
      else $error("sensor type did not follow write");

   vtime_pin_a: assert property (
      REG_WR && REG_ADDR == VTIME_ADDR
      |=> PRECHG_THRESH == $past(REG_WDATA[VT_PRETH]))
      else $error("precharge threshold did not follow write");

   pre_to_fast_a: assert property (
      state_q == ST_PRE && !BATT_LOW && !pre_exp && !hold
      |=> state_q == ST_FAST)
      else $error("precharge did not hand over to fast charge");

   readback_a: assert property (
      REG_RD && REG_ADDR == VTIME_ADDR |=> REG_RDATA == $past(vtime_q))
      else $error("read data wrong");

   unmapped_read_a: assert property (
      REG_RD && REG_ADDR != STATUS_ADDR && REG_ADDR != CTRL_ADDR
      && REG_ADDR != VTIME_ADDR |=> REG_RDATA == UNMAPPED_VAL)
      else $error("unmapped read returned data");

   // Status lags the state by one cycle
   fast_charge_c: cover property (state_q == ST_FAST ##2 status_q[ST_TERM]);
   restart_c: cover property (ctrl_q[CT_RESTART] ##1 !ctrl_q[CT_RESTART]
      ##[1:4] CHARGE_ON);
   pre_to_fast_c: cover property (state_q == ST_PRE ##1 state_q == ST_FAST);
   half_speed_c: cover property (tmr_run && tmr_half);

endmodule // chg_regs

// *** hw/chg_timer.sv ***
// Precharge and fast-charge safety timer with a minute prescaler.
// Assumes the caller clears it on every phase change and holds run low
// whenever the timers must not advance.
`timescale 1ns/1ps

module chg_timer
   import chg_pkg::*;
#(
   parameter logic [31:0] MIN_CYCLES = MINUTE_CYCLES
)
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic clear,
   input wire logic run,
   input wire logic half,
   input wire logic precharge,
   input wire logic [MIN_W-1:0] fast_limit,
   input wire logic [MIN_W-1:0] pre_limit,
   output logic pre_expired,
   output logic fast_expired
);

   logic [31:0] cyc_q, cyc_d;
   logic [MIN_W-1:0] min_q, min_d;
   logic pace_q, pace_d;
   logic pre_q, pre_d, fast_q, fast_d;
   logic step, wrap;

   always_comb
   begin
      // Half speed lets only every other cycle count
      step = run && (!half || pace_q);
      wrap = (cyc_q == MIN_CYCLES - 32'h0000_0001);
      pace_d = (run && half) ? !pace_q : 1'b0;
      cyc_d = cyc_q;
      min_d = min_q;
      pre_d = pre_q;
      fast_d = fast_q;
      if (clear)
      begin
         cyc_d = '0;
         min_d = '0;
         pre_d = 1'b0;
         fast_d = 1'b0;
      end
      else
      begin
         if (step)
         begin
            cyc_d = wrap ? 32'h0000_0000 : cyc_q + 32'h0000_0001;
            if (wrap && !pre_q && !fast_q)
               min_d = min_q + 9'h001;
         end
         if (precharge && min_q >= pre_limit)
            pre_d = 1'b1;
         if (!precharge && min_q >= fast_limit)
            fast_d = 1'b1;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         cyc_q <= '0;
         min_q <= '0;
         pace_q <= 1'b0;
         pre_q <= 1'b0;
         fast_q <= 1'b0;
      end
      else
      begin
         cyc_q <= cyc_d;
         min_q <= min_d;
         pace_q <= pace_d;
         pre_q <= pre_d;
         fast_q <= fast_d;
      end
   end

   assign pre_expired = pre_q;
   assign fast_expired = fast_q;

   hold_when_stopped_a: assert property (
      @(posedge clk) disable iff (!resetn)
      !run && !clear |=> $stable(cyc_q))
      else $error("timer advanced while stopped");

   half_pace_a: assert property (
      @(posedge clk) disable iff (!resetn)
      run && half && !clear && $past(run && half && !clear) && $stable(cyc_q)
      |=> !$stable(cyc_q) || clear)
      else $error("half-speed timer skipped two cycles");

endmodule // chg_timer

// *** test/chg_host.sv ***
// Host model: byte writes and reads on the register port.
// Assumes the bench pops exp_q when read data appears.
`timescale 1ns/1ps

module chg_host
(
   input wire logic clk,
   output logic [7:0] addr,
   output logic [7:0] wdata,
   output logic wr,
   output logic rd
);
   logic [15:0] exp_q[$];

   initial
   begin
      addr = 8'h00;
      wdata = 8'h00;
      wr = 1'b0;
      rd = 1'b0;
   end

   task automatic write(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      wdata <= ~d;
   endtask

   // Mask and expected byte are noted as the read is issued
   task automatic read(input logic [7:0] a, input logic [7:0] m,
                       input logic [7:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      exp_q.push_back({m, e});
      @(posedge clk);
      rd <= 1'b0;
   endtask

   // Restart is a set and then a clear of the restart bit
   task automatic restart(input logic [7:0] c);
      write(8'h04, c | 8'h08);
      write(8'h04, c & 8'hF7);
   endtask
endmodule // chg_host

// *** test/chg_regs_tb_top.sv ***
// Bench for the charger register bank with a host model.
// Assumes a short timer minute so the safety timers expire quickly.
`timescale 1ns/1ps

module chg_regs_tb_top;
   import chg_pkg::*;
   localparam logic [31:0] MIN_CYC = 32'h0000_0002;
   logic CLK;
   logic RESETN;
   logic [7:0] REG_ADDR;
   logic [7:0] REG_WDATA;
   logic REG_WR;
   logic REG_RD;
   logic [7:0] REG_RDATA;
   logic [5:0] ana;
   logic CHARGE_ON;
   logic CHARGER_HOLD;
   logic SENSOR_TYPE;
   logic PRECHG_THRESH;
   logic [1:0] CHARGE_VSEL;
   logic rd_seen;
   int n_fail;
   int n_compared;
   logic [31:0] seed;

   chg_host i_chg_host (.clk(CLK), .addr(REG_ADDR), .wdata(REG_WDATA),
      .wr(REG_WR), .rd(REG_RD));

   chg_regs #(.MINUTE_CYC(MIN_CYC)) i_chg_regs (.CLK(CLK),
      .RESETN(RESETN), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
      .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
      .CHIP_HOT(ana[0]), .INPUT_LOOP(ana[1]), .BATT_TEMP_OUT(ana[2]),
      .SENSOR_MISSING(ana[3]), .TERM_CURRENT(ana[4]), .BATT_LOW(ana[5]),
      .CHARGE_ON(CHARGE_ON), .CHARGER_HOLD(CHARGER_HOLD),
      .SENSOR_TYPE(SENSOR_TYPE), .PRECHG_THRESH(PRECHG_THRESH),
      .CHARGE_VSEL(CHARGE_VSEL));

   initial
   begin
      CLK = 1'b0;
      forever #12.5 CLK = ~CLK;
   end

   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction

   task automatic check(input string nm, input logic [7:0] seen,
                        input logic [7:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic conclude();
      $display("checks %0d mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // Read data stands one cycle after the sampled strobe
   always @(posedge CLK)
      rd_seen <= REG_RD & RESETN;

   always @(negedge CLK)
   begin
      logic [15:0] me;
      if (rd_seen === 1'b1)
      begin
         me = i_chg_host.exp_q.pop_front();
         check("rdata", REG_RDATA & me[15:8], me[7:0] & me[15:8]);
      end
   end

   task automatic cyc(input int n);
      repeat (n) @(posedge CLK);
      #1;
   endtask

   task automatic env(input logic [5:0] v);
      @(posedge CLK);
      ana <= v;
   endtask

   task automatic wait_off(input int lim, output int n);
      n = 0;
      while (CHARGE_ON !== 1'b0 && n < lim)
      begin
         cyc(1);
         n++;
      end
   endtask

   initial
   begin
      #500000;
      n_fail++;
      conclude();
   end

   initial
   begin
      logic [7:0] d;
      logic [7:0] c;
      logic [7:0] m[4];
      logic [7:0] e[4];
      logic [5:0] v[4];
      int n;
      RESETN = 1'b0;
      ana = 6'h00;
      n_fail = 0;
      n_compared = 0;
      seed = 32'h0000_7a44;
      cyc(12);
      check("on_rst", {7'h00, CHARGE_ON}, 8'h00);
      check("out_rst", {3'h0, SENSOR_TYPE, CHARGER_HOLD, PRECHG_THRESH,
         CHARGE_VSEL}, 8'h10);
      @(posedge CLK);
      RESETN <= 1'b1;
      i_chg_host.read(CTRL_ADDR, 8'hFF, 8'hB1);
      i_chg_host.read(VTIME_ADDR, 8'hFF, 8'h80);
      i_chg_host.read(8'h07, 8'hFF, 8'h00);
      i_chg_host.read(STATUS_ADDR, 8'hFF, 8'h08);
      i_chg_host.write(STATUS_ADDR, 8'hF7);
      i_chg_host.read(STATUS_ADDR, 8'hFF, 8'h08);
      for (int i = 0; i < 4; i++)
      begin
         seed = xs(seed);
         d = seed[7:0] & 8'h7F;
         i_chg_host.write(VTIME_ADDR, d);
         i_chg_host.read(VTIME_ADDR, 8'hFF, d);
         cyc(1);
         check("vtime_out", {5'h00, PRECHG_THRESH, CHARGE_VSEL},
            {5'h00, d[6:4]});
         c = {2'(i), 1'b1, seed[8], 4'h1};
         i_chg_host.write(CTRL_ADDR, c);
         i_chg_host.read(CTRL_ADDR, 8'hFF, c);
         cyc(1);
         check("sensor", {7'h00, SENSOR_TYPE}, {7'h00, c[4]});
      end
      v = '{6'h01, 6'h02, 6'h08, 6'h04};
      m = '{8'hFF, 8'hFF, 8'h01, 8'h21};
      e = '{8'h88, 8'h48, 8'h01, 8'h21};
      for (int i = 0; i < 4; i++)
      begin
         env(v[i]);
         cyc(3);
         i_chg_host.read(STATUS_ADDR, m[i], e[i]);
      end
      check("on_hot", {7'h00, CHARGE_ON}, 8'h00);
      env(6'h00);
      c = 8'hB1;
      i_chg_host.write(CTRL_ADDR, c | 8'h08);
      cyc(2);
      check("hold", {7'h00, CHARGER_HOLD, CHARGE_ON}, 8'h02);
      i_chg_host.write(CTRL_ADDR, c);
      cyc(3);
      check("on_rst2", {7'h00, CHARGE_ON}, 8'h01);
      env(6'h10);
      cyc(4);
      check("on_term", {7'h00, CHARGE_ON}, 8'h00);
      i_chg_host.read(STATUS_ADDR, 8'h18, 8'h10);
      i_chg_host.restart(c | 8'h04);
      cyc(10);
      check("on_tdis", {7'h00, CHARGE_ON}, 8'h01);
      env(6'h00);
      i_chg_host.write(CTRL_ADDR, c & 8'hFE);
      cyc(2);
      check("on_dis", {7'h00, CHARGE_ON}, 8'h00);
      c = 8'h31;
      i_chg_host.restart(c | 8'h02);
      cyc(600);
      check("on_timer_suspend", {7'h00, CHARGE_ON}, 8'h01);
      i_chg_host.write(CTRL_ADDR, c);
      wait_off(600, n);
      check("fast_time", {7'h00, 1'(n >= 475 && n <= 500)}, 8'h01);
      i_chg_host.read(STATUS_ADDR, 8'h04, 8'h04);
      env(6'h20);
      i_chg_host.restart(c);
      // Charger comes on one edge after the restart bit clears
      cyc(1);
      wait_off(200, n);
      check("pre_time", {7'h00, 1'(n >= 55 && n <= 70)}, 8'h01);
      i_chg_host.read(STATUS_ADDR, 8'h06, 8'h06);
      i_chg_host.write(VTIME_ADDR, 8'h80);
      env(6'h21);
      i_chg_host.restart(c);
      cyc(1);
      wait_off(300, n);
      check("half_time", {7'h00, 1'(n >= 115 && n <= 135)}, 8'h01);
      env(6'h20);
      i_chg_host.restart(8'h11);
      cyc(150);
      check("on_tmr_off", {7'h00, CHARGE_ON}, 8'h01);
      // Battery rises above the threshold: precharge hands over to fast
      env(6'h00);
      cyc(3);
      i_chg_host.read(STATUS_ADDR, 8'h0F, 8'h08);
      check("on_fast", {7'h00, CHARGE_ON}, 8'h01);
      cyc(2);
      conclude();
   end
endmodule // chg_regs_tb_top
